// [csc_pkg.sv]
// Shared constants and types for the cascade serial select block.
// Assumes one system clock domain; all serial pins arrive asynchronously.
package csc_pkg;

    // ************************************************************
    // Byte framing
    // ************************************************************
    localparam int          BYTE_BITS = 8;
    localparam int          BIT_W     = 3;
    localparam logic [2:0]  BIT_FIRST = 3'h0;
    localparam logic [2:0]  BIT_LAST  = 3'h7;
    localparam int          LEN_W     = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        PIN_IDLE_HI = 1'h1;
    localparam logic        SCLK_IDLE   = 1'h0;
    localparam logic [7:0]  BYTE_RST    = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        CSC_IDLE = 2'b00,
        CSC_WAIT = 2'b01,
        CSC_XFER = 2'b10,
        CSC_DONE = 2'b11
    } csc_state_t;

    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic din;
        logic chain_enable_in;
    } csc_pins_t;

    typedef struct packed {
        logic dout;
        logic dout_oe_b;
        logic chain_pass_out;
    } csc_drive_t;

endpackage

// [csc_sync3.sv]
// Three-stage synchroniser with a two-stage agreement filter and edge pulses.
// Assumes the input is asynchronous to sys_clk and rst_b is synchronous.
`timescale 1ns/1ns
`default_nettype none
module csc_sync3 #(
    parameter logic RST_VAL = 1'h1
) (
    input  wire logic sys_clk,   // System clock.
    input  wire logic rst_b,     // Synchronous reset, active low.
    input  wire logic pin_in,    // Asynchronous pin.
    output logic      level,     // Filtered level.
    output logic      rose,      // One-cycle pulse on a filtered rise.
    output logic      fell       // One-cycle pulse on a filtered fall.
);

    logic s1_q, s2_q, s3_q, lvl_q;
    logic s1_d, s2_d, s3_d, lvl_d;

    always_comb begin
        s1_d  = pin_in;
        s2_d  = s1_q;
        s3_d  = s2_q;
        // The first stage is never looked at; only stages two and three vote.
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
    assign rose  = lvl_d & ~lvl_q;
    assign fell  = ~lvl_d & lvl_q;

endmodule // csc_sync3
`default_nettype wire

// [csc_select.sv]
// Chip-select and daisy-chain handoff for a cascadable serial port.
// Assumes a command decoder on sys_clk supplies transmit bytes and the length.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Chain enable low with select low in the last cycle of a byte starts this device on the next byte.
// - After the requested bytes the output floats and input bits are ignored until a new select.
// - The chain enable input is sampled on each serial clock rise while selected.
// - The pass output goes low in the last cycle of the last byte so the next device follows on.
// - The pass output falls only after a serial clock rise; it returns high when deselected.
// - A select fall with chain enable low opens input and output at once.
// - With select high no bits are taken and the output floats.
// - Input bits are taken on clock falls and output bits launched on clock rises.
// - A chain enable fall while waiting to join turns the output driver on.
module csc_select #(
    parameter int LEN_W = csc_pkg::LEN_W
) (
    input  wire logic                sys_clk,     // System clock, 100 MHz.
    input  wire logic                rst_b,       // Synchronous reset, active low.
    input  wire csc_pkg::csc_pins_t  pins,        // Serial pins from the host and chain.
    output csc_pkg::csc_drive_t      drive,       // Serial pins toward host and chain.
    input  wire logic [7:0]          tx_data,     // Next byte to send.
    input  wire logic [LEN_W-1:0]    xfer_len,    // Bytes in this transfer, command included.
    output logic                     tx_req,      // Pulse: present the next byte.
    output logic [7:0]               rx_data,     // Last byte received.
    output logic                     rx_valid,    // Pulse: rx_data is new.
    output logic                     active       // Level: transfer in progress.
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic sclk_lvl, sclk_rise, sclk_fall;
    logic cs_lvl, cs_fell, cs_rose, desel;
    logic din_lvl;
    logic chain_lvl, chain_fell;

    csc_sync3 #(.RST_VAL(csc_pkg::SCLK_IDLE)) u_sclk (
        .sys_clk (sys_clk), .rst_b (rst_b), .pin_in (pins.sclk),
        .level (sclk_lvl), .rose (sclk_rise), .fell (sclk_fall));
    csc_sync3 #(.RST_VAL(csc_pkg::PIN_IDLE_HI)) u_cs (
        .sys_clk (sys_clk), .rst_b (rst_b), .pin_in (pins.cs_b),
        .level (cs_lvl), .rose (cs_rose), .fell (cs_fell));
    csc_sync3 #(.RST_VAL(csc_pkg::PIN_IDLE_HI)) u_din (
        .sys_clk (sys_clk), .rst_b (rst_b), .pin_in (pins.din),
        .level (din_lvl), .rose (), .fell ());
    csc_sync3 #(.RST_VAL(csc_pkg::PIN_IDLE_HI)) u_chain (
        .sys_clk (sys_clk), .rst_b (rst_b), .pin_in (pins.chain_enable_in),
        .level (chain_lvl), .rose (), .fell (chain_fell));

    // Select level as it stands after this edge. The registered level lags the edge pulses by one cycle.
    // Testing it alone would send the select-fall cycle down the deselected branch, and no transfer would start.
    assign desel = (cs_lvl & ~cs_fell) | cs_rose;

    // ************************************************************
    // Transfer state
    // ************************************************************
    csc_pkg::csc_state_t state_q, state_d;
    logic [2:0]       bit_q, bit_d;
    logic [LEN_W-1:0] byte_q, byte_d;
    logic [7:0]       tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, rx_q, rx_d;
    logic             chain_smp_q, chain_smp_d;
    logic             dout_q, dout_d, oe_b_q, oe_b_d, pass_q, pass_d;
    logic             txr_q, txr_d, rxv_q, rxv_d;
    logic             last_byte;

    assign last_byte = ((byte_q + {{(LEN_W-1){1'b0}}, 1'b1}) >= xfer_len);

    always_comb begin
        state_d     = state_q;
        bit_d       = bit_q;
        byte_d      = byte_q;
        tx_sh_d     = tx_sh_q;
        rx_sh_d     = rx_sh_q;
        rx_d        = rx_q;
        chain_smp_d = chain_smp_q;
        dout_d      = dout_q;
        oe_b_d      = oe_b_q;
        pass_d      = pass_q;
        txr_d       = 1'b0;
        rxv_d       = 1'b0;
        if (desel) begin
            // Deselected: float, take nothing, rearm the chain.
            state_d = csc_pkg::CSC_IDLE;
            oe_b_d  = 1'b1;
            pass_d  = 1'b1;
            bit_d   = csc_pkg::BIT_FIRST;
            byte_d  = '0;
        end else begin
            if (sclk_rise) begin
                chain_smp_d = chain_lvl;
                if (state_q == csc_pkg::CSC_XFER) begin
                    // Bit 0 of each byte loads the freshly offered byte.
                    if (bit_q == csc_pkg::BIT_FIRST) begin
                        dout_d  = tx_data[7];
                        tx_sh_d = {tx_data[6:0], 1'b0};
                    end else begin
                        dout_d  = tx_sh_q[7];
                        tx_sh_d = {tx_sh_q[6:0], 1'b0};
                    end
                    if ((bit_q == csc_pkg::BIT_LAST) && last_byte) begin
                        pass_d = 1'b0;
                    end
                end
            end
            if (sclk_fall) begin
                bit_d = bit_q + 3'h1;
                if (state_q == csc_pkg::CSC_XFER) begin
                    rx_sh_d = {rx_sh_q[6:0], din_lvl};
                end
            end
            unique case (state_q)
                csc_pkg::CSC_IDLE: begin
                    if (cs_fell) begin
                        bit_d  = csc_pkg::BIT_FIRST;
                        byte_d = '0;
                        if (!chain_lvl) begin
                            state_d = csc_pkg::CSC_XFER;
                            oe_b_d  = 1'b0;
                            txr_d   = 1'b1;
                        end else begin
                            state_d = csc_pkg::CSC_WAIT;
                        end
                    end
                end
                csc_pkg::CSC_WAIT: begin
                    if (chain_fell) begin
                        oe_b_d = 1'b0;
                    end
                    if (sclk_fall && (bit_q == csc_pkg::BIT_LAST) && !chain_smp_q) begin
                        state_d = csc_pkg::CSC_XFER;
                        oe_b_d  = 1'b0;
                        byte_d  = '0;
                        txr_d   = 1'b1;
                    end
                end
                csc_pkg::CSC_XFER: begin
                    if (sclk_fall && (bit_q == csc_pkg::BIT_LAST)) begin
                        rx_d  = {rx_sh_q[6:0], din_lvl};
                        rxv_d = 1'b1;
                        if (last_byte) begin
                            state_d = csc_pkg::CSC_DONE;
                            oe_b_d  = 1'b1;
                        end else begin
                            byte_d = byte_q + {{(LEN_W-1){1'b0}}, 1'b1};
                            txr_d  = 1'b1;
                        end
                    end
                end
                csc_pkg::CSC_DONE: begin
                    // Input is ignored until the next select fall.
                    oe_b_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q     <= csc_pkg::CSC_IDLE;
            bit_q       <= csc_pkg::BIT_FIRST;
            byte_q      <= '0;
            tx_sh_q     <= csc_pkg::BYTE_RST;
            rx_sh_q     <= csc_pkg::BYTE_RST;
            rx_q        <= csc_pkg::BYTE_RST;
            chain_smp_q <= csc_pkg::PIN_IDLE_HI;
            dout_q      <= 1'b0;
            oe_b_q      <= 1'b1;
            pass_q      <= 1'b1;
            txr_q       <= 1'b0;
            rxv_q       <= 1'b0;
        end else begin
            state_q     <= state_d;
            bit_q       <= bit_d;
            byte_q      <= byte_d;
            tx_sh_q     <= tx_sh_d;
            rx_sh_q     <= rx_sh_d;
            rx_q        <= rx_d;
            chain_smp_q <= chain_smp_d;
            dout_q      <= dout_d;
            oe_b_q      <= oe_b_d;
            pass_q      <= pass_d;
            txr_q       <= txr_d;
            rxv_q       <= rxv_d;
        end
    end

    assign drive                = '{dout: dout_q, dout_oe_b: oe_b_q, chain_pass_out: pass_q};
    assign tx_req               = txr_q;
    assign rx_data              = rx_q;
    assign rx_valid             = rxv_q;
    assign active               = (state_q == csc_pkg::CSC_XFER);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence seq_byte_end;
        sclk_fall && (bit_q == csc_pkg::BIT_LAST) && !desel;
    endsequence

    sequence seq_last_rise;
        sclk_rise && (bit_q == csc_pkg::BIT_LAST) && last_byte && !desel;
    endsequence

    AST_DESELECT_QUIET: assert property (desel |=> oe_b_q && !rxv_q)
        else $error("output driven or byte taken while deselected");
    AST_SELECT_START: assert property ((state_q == csc_pkg::CSC_IDLE) && cs_fell && !chain_lvl && !desel
        |=> (state_q == csc_pkg::CSC_XFER) && !oe_b_q && txr_q)
        else $error("select fall with chain low did not open the port");
    AST_CHAIN_SAMPLE: assert property (sclk_rise && !desel |=> chain_smp_q == $past(chain_lvl))
        else $error("chain enable not sampled on clock rise");
    AST_JOIN_NEXT_BYTE: assert property ((state_q == csc_pkg::CSC_WAIT) && !chain_smp_q ##0 seq_byte_end
        |=> (state_q == csc_pkg::CSC_XFER) ##1 (bit_q == csc_pkg::BIT_FIRST))
        else $error("device did not join at the byte boundary");
    AST_DONE_QUIET: assert property ((state_q == csc_pkg::CSC_DONE) |=> oe_b_q && !rxv_q && !txr_q)
        else $error("finished device still active on the port");
    AST_PASS_LAST: assert property ((state_q == csc_pkg::CSC_XFER) ##0 seq_last_rise |=> !pass_q)
        else $error("pass output not low in last cycle of last byte");
    AST_PASS_ON_RISE: assert property ($fell(pass_q) |-> $past(sclk_rise))
        else $error("pass output changed without a clock rise");
    AST_RX_ON_FALL: assert property (rxv_q |-> $past(sclk_fall) && $past(state_q == csc_pkg::CSC_XFER))
        else $error("byte completed away from a clock fall");
    AST_DOUT_ON_RISE: assert property (!oe_b_q && $changed(dout_q) |-> $past(sclk_rise))
        else $error("output bit changed away from a clock rise");
    AST_CHAIN_FALL_OE: assert property ((state_q == csc_pkg::CSC_WAIT) && chain_fell && !desel |=> !oe_b_q)
        else $error("chain fall did not enable the driver");
    AST_BYTE_ORIGIN: assert property ((state_q == csc_pkg::CSC_IDLE) && cs_fell && !desel
        |=> (bit_q == csc_pkg::BIT_FIRST) && (byte_q == '0))
        else $error("byte count not restarted at select fall");

endmodule // csc_select
`default_nettype wire

// [csc_host.sv]
// Behavioural host controller and chain neighbour that drive the select block's serial pins.
// Assumes the bench calls one task at a time; every pin change lands on a sys_clk fall.
`timescale 1ns/1ns
`default_nettype none
module csc_host (
    input  wire logic                sys_clk,  // System clock, 100 MHz.
    output csc_pkg::csc_pins_t       pins,     // Pins toward the device.
    input  wire csc_pkg::csc_drive_t drive     // Pins from the device.
);
    logic dout_last = 1'h0;
    logic dout_wire;

    // ************************************************************
    // Output pin resolution
    // ************************************************************
    // A released output shows the inverse of its last driven bit, so a stale value cannot pass.
    always @(posedge sys_clk) if (drive.dout_oe_b === 1'h0) dout_last <= drive.dout;
    assign dout_wire = (drive.dout_oe_b === 1'h0) ? drive.dout : ~dout_last;

    initial begin
        pins = '{sclk: 1'h0, cs_b: 1'h1, din: 1'h1, chain_enable_in: 1'h1};
    end

    // ************************************************************
    // Pin tasks
    // ************************************************************
    task automatic wait_clk(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic set_cs(input logic v);
        wait_clk(1);
        pins.cs_b = v;
        wait_clk(9);
    endtask

    task automatic set_chain(input logic v);
        wait_clk(1);
        pins.chain_enable_in = v;
        wait_clk(9);
    endtask

    // Serial clock stands low between bytes; 80 ns high and 80 ns low gives the 160 ns period.
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.din = tx[i];
            wait_clk(8);
            pins.sclk = 1'h1;
            wait_clk(8);
            rx[i] = dout_wire;
            pins.sclk = 1'h0;
        end
    endtask
endmodule // csc_host
`default_nettype wire

// [csc_select_bench.sv]
// Self-checking bench for the cascade select block, driven through the host model.
// Assumes csc_pkg, csc_sync3, csc_select and csc_host are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
module csc_select_bench;
    logic               sys_clk;
    logic               rst_b;
    csc_pkg::csc_pins_t pins;
    csc_pkg::csc_drive_t drive;
    localparam logic [7:0] TX_STEP = 8'h35;
    logic [7:0]         tx_data = 8'h00;
    logic [7:0]         xfer_len;
    logic               tx_req;
    logic [7:0]         rx_data;
    logic               rx_valid;
    logic               active;
    int                 n_mismatch;
    int                 checked;
    int                 n_rx = 0;
    int                 n_tx = 0;
    int                 base;
    logic [7:0]         rx_last;
    logic [7:0]         got;

    csc_select u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins), .drive(drive), .tx_data(tx_data),
        .xfer_len(xfer_len), .tx_req(tx_req), .rx_data(rx_data), .rx_valid(rx_valid), .active(active));
    csc_host u_host (.sys_clk(sys_clk), .pins(pins), .drive(drive));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (rx_valid === 1'h1) begin
            n_rx <= n_rx + 1;
            rx_last <= rx_data;
        end
        if (tx_req === 1'h1) n_tx <= n_tx + 1;
    end

    // Each byte request offers a fresh value, so a byte sent twice or a skipped request shows up.
    always @(negedge sys_clk) begin
        if (tx_req === 1'h1) tx_data = tx_data + TX_STEP;
    end

    // ************************************************************
    // Checking and verdict
    // ************************************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check("oe_b", {7'h00, drive.dout_oe_b}, 8'h01);
        check("pass", {7'h00, drive.chain_pass_out}, 8'h01);
        check("active", {7'h00, active}, 8'h00);
        check("rx_data", rx_data, 8'h00);
    endtask

    task automatic t_single();
        logic [7:0] exp_tx;
        exp_tx = tx_data + TX_STEP;
        xfer_len = 8'h01;
        base = n_rx;
        u_host.set_chain(1'h0);
        check("oe_b idle", {7'h00, drive.dout_oe_b}, 8'h01);
        u_host.set_cs(1'h0);
        check("oe_b sel", {7'h00, drive.dout_oe_b}, 8'h00);
        u_host.xfer_byte(8'h3C, got);
        check("dout byte", got, exp_tx);
        u_host.wait_clk(10);
        check("pass low", {7'h00, drive.chain_pass_out}, 8'h00);
        check("oe_b done", {7'h00, drive.dout_oe_b}, 8'h01);
        check("rx byte", rx_last, 8'h3C);
        check("rx count", 8'(n_rx - base), 8'h01);
        u_host.set_cs(1'h1);
        check("pass high", {7'h00, drive.chain_pass_out}, 8'h01);
    endtask

    task automatic t_long();
        int         tx0;
        logic [7:0] exp_tx;
        exp_tx = tx_data + TX_STEP;
        tx0 = n_tx;
        xfer_len = 8'h02;
        base = n_rx;
        u_host.set_cs(1'h0);
        u_host.xfer_byte(8'h81, got);
        check("dout b1", got, exp_tx);
        u_host.xfer_byte(8'h42, got);
        check("dout b2", got, exp_tx + TX_STEP);
        u_host.xfer_byte(8'hFF, got);
        check("oe_b after", {7'h00, drive.dout_oe_b}, 8'h01);
        check("pass after", {7'h00, drive.chain_pass_out}, 8'h00);
        check("tx count", 8'(n_tx - tx0), 8'h02);
        check("rx extra", 8'(n_rx - base), 8'h02);
        check("rx last", rx_last, 8'h42);
        u_host.set_cs(1'h1);
    endtask

    task automatic t_deselected();
        base = n_rx;
        u_host.xfer_byte(8'h99, got);
        u_host.wait_clk(10);
        check("rx desel", 8'(n_rx - base), 8'h00);
        check("oe_b desel", {7'h00, drive.dout_oe_b}, 8'h01);
        check("act desel", {7'h00, active}, 8'h00);
    endtask

    task automatic t_waiting();
        int         tx0;
        logic [7:0] exp_tx;
        exp_tx = tx_data + TX_STEP;
        // A length of zero is taken as one byte.
        xfer_len = 8'h00;
        u_host.set_chain(1'h1);
        base = n_rx;
        u_host.set_cs(1'h0);
        check("oe_b wait", {7'h00, drive.dout_oe_b}, 8'h01);
        u_host.xfer_byte(8'h11, got);
        u_host.set_chain(1'h0);
        check("oe_b chain", {7'h00, drive.dout_oe_b}, 8'h00);
        tx0 = n_tx;
        u_host.xfer_byte(8'h22, got);
        u_host.wait_clk(10);
        check("join req", 8'(n_tx - tx0), 8'h01);
        u_host.xfer_byte(8'h6E, got);
        u_host.wait_clk(10);
        check("join dout", got, exp_tx);
        check("join pass", {7'h00, drive.chain_pass_out}, 8'h00);
        check("join rx", rx_last, 8'h6E);
        check("join count", 8'(n_rx - base), 8'h01);
        u_host.set_cs(1'h1);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        n_mismatch = 0;
        checked = 0;
        rst_b = 1'h0;
        xfer_len = 8'h01;
        repeat (10) @(negedge sys_clk);
        rst_b = 1'h1;
        @(negedge sys_clk);
        t_reset();
        t_single();
        t_long();
        t_deselected();
        t_waiting();
        finish_test();
    end

    // A hang in the sequence counts as a mismatch and still reaches the verdict.
    initial begin
        #500000;
        n_mismatch++;
        finish_test();
    end
endmodule // csc_select_bench
`default_nettype wire
